// ---- design/alarm_ctrl_defs.svh ----
`ifndef ALARM_CTRL_DEFS_SVH
`define ALARM_CTRL_DEFS_SVH

// clock and flash timing
`define CLK_PERIOD_NS  50
`define BLINK_HALF_NS  500000000

// parameter store geometry and bus map
`define NUM_PARAMS     32
`define ADDR_W         7
`define A_ACCESS_BASE  7'h20
`define A_STATUS       7'h40

// parameter indices
`define P_SETPOINT     5'h00
`define P_ALM_HIGH     5'h01
`define P_ALM_LOW      5'h02
`define P_ALM_BAND     5'h03
`define P_BRK_LEVEL    5'h04
`define P_ALM_MODE     5'h05
`define P_OP2_SEL      5'h06
`define P_OP2_FUNC     5'h07
`define P_HEATCOOL     5'h08
`define P_MAN_AUTH     5'h09
`define P_CAL_OFFSET   5'h0a

// defaults, values in tenths
`define D_SETPOINT     16'h00fa
`define D_ALM_HIGH     16'h03e8
`define D_ALM_BAND     16'h0032
`define D_MAN_AUTH     16'h0001
`define D_ACCESS       2'h2

// output level limits in tenths of a percent
`define LEVEL_MAX      16'h03e8
`define LEVEL_MIN_HC   16'hfc19
`define LEVEL_MIN_H    16'h0000

`endif

// ---- design/alarm_ctrl_pkg.sv ----
package alarm_ctrl_pkg;

    typedef enum logic [1:0] {MODE_OFF, MODE_LATCH, MODE_NONLATCH} alarm_mode_e;
    typedef enum logic [1:0] {ACC_HIDDEN, ACC_READ, ACC_RW} access_e;
    typedef enum logic [1:0] {MOD_TRIAC, MOD_LOGIC, MOD_RELAY, MOD_DC} module_e;
    typedef enum logic [1:0] {UP_MEASURED, UP_BREAK, UP_UNDERRANGE} upper_ann_e;
    typedef enum logic [1:0] {LOW_SETPOINT, LOW_OUTPUT, LOW_ALARM_TYPE, LOW_FAULT} lower_ann_e;

    typedef struct packed {
        logic        valid;
        logic        openCircuit;
        logic [15:0] value;
    } meas_s;

    typedef struct packed {
        logic parameterButton;
        logic raise;
        logic lower;
        logic autoManual;
    } buttons_s;

    typedef struct packed {
        logic [31:0][15:0] param;
        logic [31:0][1:0]  access;
        logic              cfgLevel;
        logic              strapDone;
        logic [23:0]       blinkCnt;
        logic              phase;
        logic [2:0]        cond;
        logic [2:0]        ann;
        logic              brkOver;
        logic              brkUnder;
        logic              manual;
        logic              refused;
        logic [15:0]       rdata;
        logic              firstAlarmOutput;
        logic              secondOutput;
        logic              loopOpen;
        logic              manualBeacon;
        logic              upperBlank;
        upper_ann_e        upperAnn;
        lower_ann_e        lowerAnn;
        logic [1:0]        alarmTypeShown;
        logic [15:0]       outputLevel;
    } state_s;

endpackage

// ---- design/alarm_sensor_break_ctrl.sv ----
`timescale 1ns/100ps
`include "alarm_ctrl_defs.svh"
// notes
// - every output is a registered copy of a field of the state struct
// - only a measurement pulse moves the conditions and the break flags
// - one blink phase serves beacon, upper flash and lower alternation
// - mode off still feeds the lower display and the second output
// - writes see the level caught at power-up, not the live link pin
// - break level writes are clamped on the way in, not refused for being out of range
// - the refused flag reflects the latest parameter or access write only
// - hidden parameters read as zero at operator level
// - raise and lower step the level by one tenth per press
// - a parameter press clears only latched types whose cause is gone
// - the span limits are parameters, set for the fitted sensor
//
module alarm_sensor_break_ctrl #(
    parameter logic signed [15:0] SPAN_HIGH    = 16'sh1388,
    parameter logic signed [15:0] SPAN_LOW     = 16'shfc18,
    parameter int                 BLINK_CYCLES = `BLINK_HALF_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         resetn,
    // straps and status from the instrument
    input  wire logic                         configLink,
    input  wire logic                         selfFault,
    input  wire alarm_ctrl_pkg::module_e      op2Module,
    // process input and control algorithm
    input  wire alarm_ctrl_pkg::meas_s        meas,
    input  wire logic [15:0]                  pidLevel,
    // front panel buttons, one-cycle pulses
    input  wire alarm_ctrl_pkg::buttons_s     buttons,
    // register port
    input  wire logic [`ADDR_W-1:0]           busAddr,
    input  wire logic [15:0]                  busWdata,
    input  wire logic                         busWr,
    input  wire logic                         busRd,
    output logic [15:0]                       busRdata,
    // alarm outputs
    output logic                              firstAlarmOutput,
    output logic                              secondOutput,
    output logic                              secondOutputLed,
    // loop and displays
    output logic                              loopOpen,
    output logic [15:0]                       outputLevel,
    output logic                              manualMode,
    output logic                              manualBeacon,
    output logic                              upperBlank,
    output alarm_ctrl_pkg::upper_ann_e        upperAnn,
    output alarm_ctrl_pkg::lower_ann_e        lowerAnn,
    output logic [1:0]                        alarmTypeShown,
    output logic                              configLevel
);

    // refuse parameter values the logic cannot serve
    initial begin
        if (BLINK_CYCLES < 1 || BLINK_CYCLES >= (1 << 24))
            $error("BLINK_CYCLES out of range");
        if (SPAN_LOW >= SPAN_HIGH)
            $error("span limits reversed");
    end

    // whole state and its next value
    alarm_ctrl_pkg::state_s st;
    alarm_ctrl_pkg::state_s next_st;

    // limit an output level to the range of the control type
    // values are signed tenths of a percent
    function automatic logic [15:0] clamp_level(input logic [15:0] v, input logic heatCool);
        logic signed [15:0] lo;
        lo = heatCool ? $signed(`LEVEL_MIN_HC) : $signed(`LEVEL_MIN_H);
        if ($signed(v) > $signed(`LEVEL_MAX))
            return `LEVEL_MAX;
        else if ($signed(v) < lo)
            return lo;
        else
            return v;
    endfunction

    // second output function allowed by the fitted module
    // only logic and relay modules can carry an alarm
    function automatic logic func_allowed(input alarm_ctrl_pkg::module_e m, input logic isAlarm);
        if (!isAlarm)
            return 1'b1;
        return (m == alarm_ctrl_pkg::MOD_LOGIC) || (m == alarm_ctrl_pkg::MOD_RELAY);
    endfunction

    // parameter visible at the present level
    // configuration level shows every parameter
    function automatic logic visible(input logic cfg, input logic [1:0] acc);
        return cfg || (acc != alarm_ctrl_pkg::ACC_HIDDEN);
    endfunction

    // factory default of each parameter
    // parameters without a stated default start at zero
    function automatic logic [15:0] default_of(input int idx);
        unique case (idx)
            `P_SETPOINT: return `D_SETPOINT;
            `P_ALM_HIGH: return `D_ALM_HIGH;
            `P_ALM_BAND: return `D_ALM_BAND;
            `P_MAN_AUTH: return `D_MAN_AUTH;
            default:     return 16'h0000;
        endcase
    endfunction

    // reset image of the whole state
    function automatic alarm_ctrl_pkg::state_s reset_state();
        alarm_ctrl_pkg::state_s r;
        r = '0;
        for (int i = 0; i < `NUM_PARAMS; i++) begin
            r.param[i]  = default_of(i);
            r.access[i] = `D_ACCESS;
        end
        return r;
    endfunction

    // constant reset image, so the async branch loads only a constant
    localparam alarm_ctrl_pkg::state_s RESET_ST = reset_state();

    // next-state logic
    always_comb begin
        logic signed [15:0] v;
        logic signed [16:0] diff;
        logic signed [16:0] band;
        logic [2:0]         cnd;
        logic [1:0]         mode;
        logic [1:0]         sel;
        logic               brk;
        logic               heatCool;
        logic               manAuth;
        logic               anyAlarm;
        logic               cfgAlarm;
        logic [4:0]         idx;
        logic               ok;
        logic [15:0]        wval;
        logic [15:0]        level;
        v        = '0;
        diff     = '0;
        band     = '0;
        cnd      = '0;
        mode     = '0;
        sel      = '0;
        brk      = 1'b0;
        heatCool = 1'b0;
        manAuth  = 1'b0;
        anyAlarm = 1'b0;
        cfgAlarm = 1'b0;
        idx      = '0;
        ok       = 1'b0;
        wval     = '0;
        level    = '0;
        next_st  = st;

        heatCool = st.param[`P_HEATCOOL][0];
        manAuth  = st.param[`P_MAN_AUTH][0];


        // catch the configuration link once after reset release
        // later changes of the link are ignored until the next reset
        if (!st.strapDone) begin
            next_st.strapDone = 1'b1;
            next_st.cfgLevel  = configLink;
        end


        // flash timebase
        // one phase flip every BLINK_CYCLES clocks drives every flash
        if (st.blinkCnt == 24'(BLINK_CYCLES - 1)) begin
            next_st.blinkCnt = '0;
            next_st.phase    = ~st.phase;
        end else begin
            next_st.blinkCnt = st.blinkCnt + 24'h000001;
        end


        // evaluate conditions on every new measurement
        // between pulses cond and break keep their last value
        if (meas.valid) begin
            v    = $signed(meas.value);
            diff = 17'(v) - 17'($signed(st.param[`P_SETPOINT]));
            band = 17'($signed(st.param[`P_ALM_BAND]));
            cnd[0] = v > $signed(st.param[`P_ALM_HIGH]);
            cnd[1] = v < $signed(st.param[`P_ALM_LOW]);
            cnd[2] = (diff > band) || (-diff > band);
            next_st.cond     = cnd;
            next_st.brkOver  = meas.openCircuit || (v > SPAN_HIGH);
            next_st.brkUnder = !meas.openCircuit && (v < SPAN_LOW);
        end


        // per type annunciation by mode
        // a latch set wins over a press in the same cycle
        for (int i = 0; i < 3; i++) begin
            mode = st.param[`P_ALM_MODE][2*i +: 2];
            unique case (mode)
                alarm_ctrl_pkg::MODE_LATCH: begin
                    if (next_st.cond[i])
                        next_st.ann[i] = 1'b1;
                    else if (buttons.parameterButton)
                        next_st.ann[i] = 1'b0;
                end
                alarm_ctrl_pkg::MODE_NONLATCH: begin
                    next_st.ann[i] = next_st.cond[i];
                end
                default: begin
                    next_st.ann[i] = 1'b0;
                end
            endcase
        end

        cfgAlarm = |next_st.ann;
        anyAlarm = cfgAlarm || (|next_st.cond);
        next_st.firstAlarmOutput = cfgAlarm;


        // second output follows its one selected type
        // select code 3 parks the second output off
        sel = st.param[`P_OP2_SEL][1:0];
        next_st.secondOutput = st.param[`P_OP2_FUNC][0] && (sel != 2'h3)
                               && next_st.cond[sel];


        // auto/manual handling
        // leaving manual needs a clear input and a fresh press
        brk = next_st.brkOver || next_st.brkUnder;
        if (buttons.autoManual) begin
            if (!st.manual && manAuth) begin
                next_st.manual = 1'b1;
            end else if (st.manual && !brk) begin
                next_st.manual = 1'b0;
            end
        end


        // output level selection
        // entering manual keeps the level, so the change is bumpless
        level = st.outputLevel;
        if (next_st.manual) begin
            if (!st.manual) begin
                level = st.outputLevel;
            end else if (manAuth && buttons.raise) begin
                level = st.outputLevel + 16'h0001;
            end else if (manAuth && buttons.lower) begin
                level = st.outputLevel - 16'h0001;
            end
        end else if (brk) begin
            level = st.param[`P_BRK_LEVEL];
        end else begin
            level = pidLevel;
        end
        next_st.outputLevel = clamp_level(level, heatCool);
        next_st.loopOpen    = brk;


        // beacon and displays
        // fault wins the lower display over alarm and manual
        next_st.manualBeacon = brk ? next_st.phase : next_st.manual;
        if (next_st.brkUnder)
            next_st.upperAnn = alarm_ctrl_pkg::UP_UNDERRANGE;
        else if (next_st.brkOver)
            next_st.upperAnn = alarm_ctrl_pkg::UP_BREAK;
        else
            next_st.upperAnn = alarm_ctrl_pkg::UP_MEASURED;
        next_st.upperBlank = cfgAlarm && !brk && next_st.phase;

        next_st.alarmTypeShown = 2'h0;
        for (int i = 2; i >= 0; i--) begin
            if (next_st.cond[i] || next_st.ann[i])
                next_st.alarmTypeShown = 2'(i);
        end
        if (selfFault)
            next_st.lowerAnn = alarm_ctrl_pkg::LOW_FAULT;
        else if (anyAlarm)
            next_st.lowerAnn = next_st.phase ? alarm_ctrl_pkg::LOW_ALARM_TYPE
                                             : alarm_ctrl_pkg::LOW_SETPOINT;
        else if (next_st.manual)
            next_st.lowerAnn = alarm_ctrl_pkg::LOW_OUTPUT;
        else
            next_st.lowerAnn = alarm_ctrl_pkg::LOW_SETPOINT;


        // register writes
        // refused writes leave the state and raise the refused flag
        idx = busAddr[4:0];
        if (busWr) begin
            if (busAddr < `A_ACCESS_BASE) begin
                ok   = st.cfgLevel || (st.access[idx] == alarm_ctrl_pkg::ACC_RW);
                wval = busWdata;
                if (idx == `P_CAL_OFFSET && !st.cfgLevel)
                    ok = 1'b0;
                if (idx == `P_BRK_LEVEL)
                    wval = clamp_level(busWdata, heatCool);
                if (idx == `P_OP2_FUNC && !func_allowed(op2Module, busWdata[0]))
                    ok = 1'b0;
                if (ok)
                    next_st.param[idx] = wval;
                next_st.refused = !ok;
            end else if (busAddr < `A_STATUS) begin
                ok = st.cfgLevel && (busWdata[1:0] != 2'h3);
                if (ok)
                    next_st.access[idx] = busWdata[1:0];
                next_st.refused = !ok;
            end
        end


        // register reads, data valid one cycle later only
        // rdata falls back to zero when no read is pending
        next_st.rdata = 16'h0000;
        if (busRd) begin
            if (busAddr < `A_ACCESS_BASE) begin
                if (visible(st.cfgLevel, st.access[idx]))
                    next_st.rdata = st.param[idx];
            end else if (busAddr < `A_STATUS) begin
                if (st.cfgLevel)
                    next_st.rdata = {14'h0000, st.access[idx]};
            end else if (busAddr == `A_STATUS) begin
                next_st.rdata = {3'h0, selfFault, st.cfgLevel, st.manual, st.brkUnder,
                                 st.brkOver, st.refused, st.ann, st.cond, st.loopOpen};
            end
        end
    end

    // state register
    // reset loads the constant image built from the defaults
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            st <= RESET_ST;
        else
            st <= next_st;
    end

    // outputs straight from the state
    // each output is a flop of the state struct, no logic after it
    assign busRdata         = st.rdata;
    assign firstAlarmOutput = st.firstAlarmOutput;
    assign secondOutput     = st.secondOutput;
    assign secondOutputLed  = st.secondOutput;
    assign loopOpen         = st.loopOpen;
    assign outputLevel      = st.outputLevel;
    assign manualMode       = st.manual;
    assign manualBeacon     = st.manualBeacon;
    assign upperBlank       = st.upperBlank;
    assign upperAnn         = st.upperAnn;
    assign lowerAnn         = st.lowerAnn;
    assign alarmTypeShown   = st.alarmTypeShown;
    assign configLevel      = st.cfgLevel;

endmodule

// ---- bench/alarm_ctrl_monitor.sv ----
`timescale 1ns/100ps
module alarm_ctrl_monitor #(
    parameter logic signed [15:0] SPAN_LOW = 16'shfc18
) (
    // clock and reset
    input wire logic                       clk_sys,
    input wire logic                       resetn,
    // watched inputs
    input wire logic                       selfFault,
    input wire alarm_ctrl_pkg::meas_s      meas,
    input wire logic                       busRd,
    // watched outputs
    input wire logic [15:0]                busRdata,
    input wire logic                       firstAlarmOutput,
    input wire logic                       secondOutput,
    input wire logic                       secondOutputLed,
    input wire logic                       loopOpen,
    input wire logic [15:0]                outputLevel,
    input wire logic                       manualMode,
    input wire logic                       manualBeacon,
    input wire logic                       upperBlank,
    input wire alarm_ctrl_pkg::upper_ann_e upperAnn,
    input wire alarm_ctrl_pkg::lower_ann_e lowerAnn,
    input wire logic                       configLevel
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // one conversion seen with the input open, or below span
    sequence s_open_meas;
        meas.valid && meas.openCircuit;
    endsequence
    sequence s_under_meas;
        meas.valid && !meas.openCircuit && ($signed(meas.value) < SPAN_LOW);
    endsequence
    // break handling and output level range
    a_open_break: assert property (s_open_meas |=> loopOpen && upperAnn == alarm_ctrl_pkg::UP_BREAK)
        else $error("open input did not open the loop");
    a_under_shown: assert property (s_under_meas |=> loopOpen && upperAnn == alarm_ctrl_pkg::UP_UNDERRANGE)
        else $error("underrange input not shown");
    a_beacon_flash: assert property (not ((loopOpen && $stable(manualBeacon)) [*6]))
        else $error("beacon steady during break");
    a_manual_keep: assert property (manualMode && loopOpen |=> manualMode)
        else $error("manual left during break");
    a_level_clamp: assert property ($signed(outputLevel) <= 16'sd1000 && $signed(outputLevel) >= -16'sd999)
        else $error("output level out of range");
    // displays and alarm outputs
    a_blank_cause: assert property (upperBlank |-> firstAlarmOutput && !loopOpen)
        else $error("upper flash without alarm");
    a_alarm_lower: assert property (not ((secondOutput && !selfFault && !manualMode
        && lowerAnn != alarm_ctrl_pkg::LOW_ALARM_TYPE) [*8]))
        else $error("lower display not alternating");
    a_led_follow: assert property (secondOutputLed == secondOutput)
        else $error("second output indicator mismatch");
    a_fault_lower: assert property (selfFault |=> lowerAnn == alarm_ctrl_pkg::LOW_FAULT)
        else $error("fault not shown");
    // register port and level strap
    a_read_idle: assert property (!busRd |=> busRdata == 16'h0000)
        else $error("read data outside read cycle");
    a_cfg_hold: assert property ($past(resetn, 2) |-> $stable(configLevel))
        else $error("level changed after power-up");
endmodule

bind alarm_sensor_break_ctrl alarm_ctrl_monitor #(.SPAN_LOW(SPAN_LOW)) mon_u (
    .clk_sys(clk_sys), .resetn(resetn), .selfFault(selfFault), .meas(meas), .busRd(busRd),
    .busRdata(busRdata), .firstAlarmOutput(firstAlarmOutput), .secondOutput(secondOutput),
    .secondOutputLed(secondOutputLed), .loopOpen(loopOpen), .outputLevel(outputLevel),
    .manualMode(manualMode), .manualBeacon(manualBeacon), .upperBlank(upperBlank),
    .upperAnn(upperAnn), .lowerAnn(lowerAnn), .configLevel(configLevel)
);

// ---- bench/front_panel_model.sv ----
`timescale 1ns/100ps
module front_panel_model (
    // clock
    input  wire logic               clk_sys,
    // sensor and buttons
    output alarm_ctrl_pkg::meas_s    meas,
    output alarm_ctrl_pkg::buttons_s buttons
);
    // idle at time zero
    initial begin
        meas    = '0;
        buttons = '0;
    end
    // one conversion pulse; idle value is the inverse, never a held sample
    task sample(input logic [15:0] v, input logic oc);
        @(posedge clk_sys);
        meas <= '{valid: 1'b1, openCircuit: oc, value: v};
        @(posedge clk_sys);
        meas <= '{valid: 1'b0, openCircuit: ~oc, value: ~v};
        #1;
    endtask
    // one-cycle press
    task press(input logic [3:0] b);
        @(posedge clk_sys);
        buttons <= b;
        @(posedge clk_sys);
        buttons <= '0;
        #1;
    endtask
endmodule

// ---- bench/alarm_sensor_break_ctrl_tb.sv ----
`timescale 1ns/100ps
module alarm_sensor_break_ctrl_tb;
    typedef struct packed {
        logic [15:0] v;
        logic        oc;
        logic        al;
        logic [1:0]  ty;
        logic [1:0]  up;
        logic        lp;
    } row_s;
    // sample, open input, alarm, type shown, upper display, loop open
    localparam row_s ROWS [9] = '{
        '{16'h012d, 1'b0, 1'b1, 2'h2, 2'h0, 1'b0}, '{16'h00fa, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0},
        '{16'h03e9, 1'b0, 1'b1, 2'h0, 2'h0, 1'b0}, '{16'hfffb, 1'b0, 1'b1, 2'h1, 2'h0, 1'b0},
        '{16'h00fa, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0}, '{16'h1389, 1'b0, 1'b0, 2'h0, 2'h1, 1'b1},
        '{16'hfc17, 1'b0, 1'b0, 2'h0, 2'h2, 1'b1}, '{16'h00fa, 1'b1, 1'b0, 2'h0, 2'h1, 1'b1},
        '{16'h1388, 1'b0, 1'b1, 2'h0, 2'h0, 1'b0}
    };
    logic                       clk_sys;
    logic                       resetn;
    logic                       configLink;
    logic                       selfFault;
    alarm_ctrl_pkg::module_e    op2Module;
    alarm_ctrl_pkg::meas_s      meas;
    alarm_ctrl_pkg::buttons_s   buttons;
    logic [15:0]                pidLevel, busWdata, busRdata, outputLevel, d;
    logic [6:0]                 busAddr;
    logic                       busWr, busRd, firstAlarmOutput, secondOutput, secondOutputLed;
    logic                       loopOpen, manualMode, manualBeacon, upperBlank, configLevel;
    alarm_ctrl_pkg::upper_ann_e upperAnn;
    alarm_ctrl_pkg::lower_ann_e lowerAnn;
    logic [1:0]                 alarmTypeShown;
    int                         failures = 0;
    int                         compares = 0;

    alarm_sensor_break_ctrl #(.BLINK_CYCLES(4)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .configLink(configLink), .selfFault(selfFault),
        .op2Module(op2Module), .meas(meas), .pidLevel(pidLevel), .buttons(buttons), .busAddr(busAddr),
        .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
        .firstAlarmOutput(firstAlarmOutput), .secondOutput(secondOutput), .secondOutputLed(secondOutputLed),
        .loopOpen(loopOpen), .outputLevel(outputLevel), .manualMode(manualMode), .manualBeacon(manualBeacon),
        .upperBlank(upperBlank), .upperAnn(upperAnn), .lowerAnn(lowerAnn), .alarmTypeShown(alarmTypeShown),
        .configLevel(configLevel)
    );
    front_panel_model pm_u (.clk_sys(clk_sys), .meas(meas), .buttons(buttons));

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        end_sim();
    end

    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // register port cycles
    task wr(input logic [6:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        busAddr  <= a;
        busWdata <= v;
        busWr    <= 1'b1;
        @(posedge clk_sys);
        busWr <= 1'b0;
    endtask
    task rd(input logic [6:0] a, output logic [15:0] q);
        @(posedge clk_sys);
        busAddr <= a;
        busRd   <= 1'b1;
        @(posedge clk_sys);
        busRd <= 1'b0;
        #1;
        q = busRdata;
    endtask
    // power-up with the link strap at the level given
    task do_reset(input logic link);
        resetn     <= 1'b0;
        configLink <= link;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        resetn    = 1'b0;
        configLink = 1'b0;
        selfFault = 1'b0;
        op2Module = alarm_ctrl_pkg::MOD_TRIAC;
        pidLevel  = 16'h0123;
        busAddr   = '0;
        busWdata  = '0;
        busWr     = 1'b0;
        busRd     = 1'b0;
        do_reset(1'b0);
        chk("configLevel", 16'h0, {15'h0, configLevel});
        rd(7'h00, d);
        chk("setpoint", 16'h00fa, d);
        rd(7'h41, d);
        chk("unmapped", 16'h0, d);
        wr(7'h0a, 16'h0005);
        rd(7'h40, d);
        chk("calRefused", 16'h1, {15'h0, d[7]});
        $display("test registers done");
        wr(7'h05, 16'h002a);
        for (int i = 0; i < 9; i++) begin
            pm_u.sample(ROWS[i].v, ROWS[i].oc);
            chk("loopOpen", {15'h0, ROWS[i].lp}, {15'h0, loopOpen});
            chk("upperAnn", {14'h0, ROWS[i].up}, {14'h0, upperAnn});
            chk("outputLevel", ROWS[i].lp ? 16'h0 : 16'h0123, outputLevel);
            if (!ROWS[i].lp) chk("alarm1", {15'h0, ROWS[i].al}, {15'h0, firstAlarmOutput});
            if (ROWS[i].al) chk("alarmType", {14'h0, ROWS[i].ty}, {14'h0, alarmTypeShown});
        end
        $display("test alarm table done");
        wr(7'h05, 16'h0001);
        pm_u.sample(16'h03e9, 1'b0);
        pm_u.press(4'h8);
        chk("ackHeld", 16'h1, {15'h0, firstAlarmOutput});
        pm_u.sample(16'h00fa, 1'b0);
        chk("latched", 16'h1, {15'h0, firstAlarmOutput});
        repeat (9) @(posedge clk_sys);
        pm_u.press(4'h8);
        chk("acked", 16'h0, {15'h0, firstAlarmOutput});
        $display("test latching done");
        wr(7'h04, 16'hf000);
        pm_u.sample(16'h00fa, 1'b1);
        chk("levelClamp", 16'h0, outputLevel);
        wr(7'h04, 16'h01f4);
        pm_u.sample(16'h00fa, 1'b1);
        chk("breakLevel", 16'h01f4, outputLevel);
        pm_u.press(4'h4);
        chk("autoRaise", 16'h01f4, outputLevel);
        pm_u.press(4'h1);
        chk("manualOn", 16'h1, {15'h0, manualMode});
        pm_u.press(4'h4);
        chk("manualRaise", 16'h01f5, outputLevel);
        repeat (12) @(posedge clk_sys);
        pm_u.press(4'h1);
        chk("manualKept", 16'h1, {15'h0, manualMode});
        pm_u.sample(16'h00fa, 1'b0);
        pm_u.press(4'h1);
        chk("manualOff", 16'h0, {15'h0, manualMode});
        @(posedge clk_sys);
        selfFault <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("fault", 16'h3, {14'h0, lowerAnn});
        @(posedge clk_sys);
        selfFault <= 1'b0;
        $display("test break and fault done");
        do_reset(1'b1);
        chk("configLevel", 16'h1, {15'h0, configLevel});
        wr(7'h07, 16'h0001);
        rd(7'h40, d);
        chk("moduleRefused", 16'h1, {15'h0, d[7]});
        @(posedge clk_sys);
        op2Module <= alarm_ctrl_pkg::MOD_LOGIC;
        wr(7'h07, 16'h0001);
        wr(7'h0a, 16'h0007);
        rd(7'h0a, d);
        chk("calibration", 16'h0007, d);
        wr(7'h23, 16'h0001);
        rd(7'h23, d);
        chk("access", 16'h0001, d);
        pm_u.sample(16'h03e9, 1'b0);
        chk("op2", 16'h1, {15'h0, secondOutput});
        chk("alarm1Off", 16'h0, {15'h0, firstAlarmOutput});
        wr(7'h08, 16'h0001);
        wr(7'h04, 16'hfc00);
        rd(7'h04, d);
        chk("breakLevelHc", 16'hfc19, d);
        @(posedge clk_sys);
        pidLevel <= 16'h0500;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("pidClampHigh", 16'h03e8, outputLevel);
        @(posedge clk_sys);
        pidLevel <= 16'hfc00;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("pidClampLow", 16'hfc19, outputLevel);
        repeat (10) @(posedge clk_sys);
        $display("test configuration done");
        end_sim();
    end
endmodule
